// ---- dv/test_trace_trigger_sequencer.sv ----
`timescale 1ns/1ps
module test_trace_trigger_sequencer;
  import tts_pkg::*;
  // ----
  // signals
  // ----
  logic clk, arst_n, line_a, line_b, ce;
  logic [6:0] stb;
  tts_cfg_t cfg_in;
  tts_branch_t br_in;
  tts_sec_t sec_in;
  logic [TERM_W-1:0] br_term, cur_term;
  logic [NUM_PAT:0] sto_in, simple_qual;
  logic state_valid, trigger, triggered, store, cfg_err;
  logic [NUM_PAT-1:0] pat_hit;
  int n_mismatch, checks_done, n_trig, n_sto, n_err, k, c;
  tts_bus_model bus (.CLK(clk), .STATE_VALID(state_valid),
    .PAT_HIT(pat_hit));
  tts_sequencer dut (.CLK(clk), .ARST_N(arst_n), .CE(ce),
    .STATE_VALID(state_valid), .PAT_HIT(pat_hit),
    .CROSS_TRIGGER_LINE_A(line_a), .CROSS_TRIGGER_LINE_B(line_b),
    .REINIT(stb[0]), .RUN_START(stb[1]), .CFG_WE(stb[2]),
    .CFG_IN(cfg_in), .BR_WE(stb[3]), .BR_TERM(br_term),
    .BR_IN(br_in), .SEC_WE(stb[4]), .SEC_IN(sec_in),
    .STO_WE(stb[5]), .STO_IN(sto_in), .SIMPLE_TRIGGER_CMD(stb[6]),
    .SIMPLE_QUAL(simple_qual), .TRIGGER(trigger),
    .TRIGGERED(triggered), .STORE(store), .CUR_TERM(cur_term),
    .CFG_ERR(cfg_err));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (trigger === 1'b1) n_trig++;
    if (store === 1'b1) n_sto++;
    if (cfg_err === 1'b1) n_err++;
  end
  // ----
  // tasks
  // ----
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // matching states expected before the branching one
  function automatic int pre_hits(input int n);
    return (n > 1) ? n - 1 : 0;
  endfunction
  task fire(input int i);
    @(negedge clk);
    stb = 7'h01 << i;
    @(negedge clk);
    stb = 7'h00;
  endtask
  task cfg(input int lv, input logic cm, input int tt, input int a);
    cfg_in = {cm, 3'(lv), 3'(tt), 2'(a)};
    fire(2);
  endtask
  task br(input int t, input logic [NUM_PAT:0] q, input logic ua,
    input int tg, input int n);
    br_term = 3'(t);
    br_in = {q, ua, 3'(tg), 16'(n)};
    fire(3);
  endtask
  task settle(input int et, input int es);
    bus.idle();
    repeat (4) @(negedge clk);
    chk(16'(n_trig), 16'(et));
    if (es >= 0) chk(16'(n_sto), 16'(es));
    n_trig = 0;
    n_sto = 0;
  endtask
  task term(input int e);
    chk({13'h0000, cur_term}, 16'(e));
  endtask
  task print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    print_verdict();
  end
  // ----
  // tests
  // ----
  initial begin
    arst_n = 1'b0;
    {line_a, line_b, stb, br_term} = 0;
    ce = 1'b1;
    {cfg_in, br_in, sec_in, sto_in, simple_qual} = 0;
    void'($urandom(97626));
    repeat (3) @(negedge clk);
    chk({trigger, triggered, store, cfg_err}, 16'h0000);
    arst_n = 1'b1;
    fire(1);
    bus.put(8'h00, 0);
    settle(1, 1);
    chk(triggered, 1'b1);
    fire(1);
    ce = 1'b0;
    bus.put(8'h00, 0);
    settle(0, 0);
    ce = 1'b1;
    chk(triggered, 1'b0);
    bus.put(8'h00, 0);
    settle(1, 1);
    bus.put(8'hFF, 0);
    settle(0, -1);
    $display("test defaults done");
    cfg(2, 0, 7, 0);
    br(0, 9'h001, 0, 1, 3);
    br(1, 9'h002, 0, 2, 1);
    sec_in = {9'h004, 3'h0};
    fire(4);
    fire(1);
    bus.put(8'h01, 0);
    bus.put(8'h01, 1);
    bus.put(8'h04, 0);
    bus.put(8'h01, 0);
    bus.put(8'h05, 0);
    bus.put(8'h01, 0);
    bus.put(8'h01, 0);
    settle(0, -1);
    term(0);
    bus.put(8'h01, 2);
    settle(0, -1);
    term(1);
    bus.put(8'h06, 0);
    settle(1, -1);
    n_err = 0;
    br(2, 9'h100, 0, 3, 1);
    repeat (3) @(negedge clk);
    chk(16'(n_err), 16'h0001);
    cfg(5, 0, 7, 0);
    fire(1);
    repeat (3) bus.put(8'h01, 0);
    settle(0, -1);
    term(1);
    bus.put(8'h02, 0);
    settle(1, -1);
    $display("test easy done");
    fire(0);
    cfg(1, 1, 2, 0);
    br(0, 9'h001, 0, 2, 1);
    br(2, 9'h002, 0, 5, 2);
    sec_in = {9'h008, 3'h6};
    fire(4);
    fire(1);
    bus.put(8'h08, 0);
    settle(0, -1);
    term(6);
    bus.put(8'h00, 0);
    settle(0, -1);
    term(7);
    bus.put(8'h00, 0);
    settle(0, -1);
    term(7);
    fire(1);
    bus.put(8'h01, 0);
    bus.put(8'h02, 0);
    settle(0, -1);
    term(2);
    bus.put(8'h02, 1);
    settle(1, -1);
    $display("test complex done");
    fire(0);
    cfg(1, 0, 7, 1);
    br(0, 9'h100, 1, 1, 0);
    fire(1);
    line_b = 1'b1;
    bus.put(8'hFF, 0);
    settle(0, -1);
    line_a = 1'b1;
    repeat (3) @(negedge clk);
    bus.put(8'h00, 0);
    settle(1, -1);
    $display("test arm done");
    fire(0);
    sto_in = 9'h040;
    br_term = 3'h0;
    fire(5);
    simple_qual = 9'h010;
    fire(6);
    fire(1);
    bus.put(8'h60, 0);
    bus.put(8'h20, 0);
    settle(0, 1);
    bus.put(8'h10, 0);
    settle(1, 0);
    fire(0);
    fire(1);
    bus.put(8'h00, 0);
    settle(1, 1);
    fire(0);
    cfg(1, 1, 7, 0);
    br_term = 3'h1;
    sto_in = 9'h002;
    fire(5);
    br_term = 3'h2;
    sto_in = 9'h001;
    fire(5);
    fire(1);
    bus.put(8'h01, 0);
    bus.put(8'h01, 0);
    bus.put(8'h03, 0);
    settle(0, 2);
    term(3);
    $display("test simple done");
    for (int i = 0; i < 4; i++) begin
      k = $urandom_range(7, 0);
      c = $urandom_range(5, 0);
      fire(0);
      br(0, {1'b0, 8'h01 << k}, 0, 1, c);
      fire(1);
      repeat (pre_hits(c)) begin
        bus.put(8'h01 << k, $urandom_range(2, 0));
        bus.put(8'($urandom) & ~(8'h01 << k), 0);
      end
      settle(0, -1);
      bus.put(8'h01 << k, 0);
      settle(1, -1);
    end
    $display("test random done");
    print_verdict();
  end
endmodule // test_trace_trigger_sequencer

// ---- dv/tts_bus_model.sv ----
`timescale 1ns/1ps
// ----
// qualified state source
// ----
module tts_bus_model
  import tts_pkg::*;
(
  // clock
  input wire logic CLK,
  // state stream
  output logic STATE_VALID,
  output logic [NUM_PAT-1:0] PAT_HIT
);
  initial begin
    STATE_VALID = 1'b0;
    PAT_HIT = 8'h5A;
  end
  // one state, then gap idle cycles
  task automatic put(input logic [NUM_PAT-1:0] h, input int gap);
    @(negedge CLK);
    STATE_VALID = 1'b1;
    PAT_HIT = h;
    repeat (gap) idle();
  endtask
  // idle: hit lines scrambled
  task automatic idle();
    @(negedge CLK);
    STATE_VALID = 1'b0;
    PAT_HIT = ~PAT_HIT;
  endtask
endmodule // tts_bus_model

// ---- rtl/tts_qual_eval.sv ----
`timescale 1ns/1ps
module tts_qual_eval
  import tts_pkg::*;
(
  // qualifier and matches
  input wire logic [NUM_PAT:0] qual,
  input wire logic [NUM_PAT-1:0] pat_hit,
  output logic hit
);
  assign hit = qual[NUM_PAT] | (|(qual[NUM_PAT-1:0] & pat_hit));
endmodule // tts_qual_eval

// ---- rtl/tts_sequencer.sv ----
`timescale 1ns/1ps
module tts_sequencer
  import tts_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic CE,
  // qualified state stream
  input wire logic STATE_VALID,
  input wire logic [NUM_PAT-1:0] PAT_HIT,
  // cross-trigger pins
  input wire logic CROSS_TRIGGER_LINE_A,
  input wire logic CROSS_TRIGGER_LINE_B,
  // configuration writes
  input wire logic REINIT,
  input wire logic RUN_START,
  input wire logic CFG_WE,
  input wire tts_pkg::tts_cfg_t CFG_IN,
  input wire logic BR_WE,
  input wire logic [TERM_W-1:0] BR_TERM,
  input wire tts_pkg::tts_branch_t BR_IN,
  input wire logic SEC_WE,
  input wire tts_pkg::tts_sec_t SEC_IN,
  input wire logic STO_WE,
  input wire logic [NUM_PAT:0] STO_IN,
  input wire logic SIMPLE_TRIGGER_CMD,
  input wire logic [NUM_PAT:0] SIMPLE_QUAL,
  // status
  output logic TRIGGER,
  output logic TRIGGERED,
  output logic STORE,
  output logic [TERM_W-1:0] CUR_TERM,
  output logic CFG_ERR
);
  import tts_pkg::*;

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  logic [1:0] line_a_sync_reg;
  logic [1:0] line_b_sync_reg;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      line_a_sync_reg <= 2'h0;
      line_b_sync_reg <= 2'h0;
    end else if (CE) begin
      line_a_sync_reg <= {line_a_sync_reg[0], CROSS_TRIGGER_LINE_A};
      line_b_sync_reg <= {line_b_sync_reg[0], CROSS_TRIGGER_LINE_B};
    end
  end

  // --------------------------------------------------------------
  // configuration
  // --------------------------------------------------------------
  tts_cfg_t cfg_reg;
  tts_branch_t br_reg [NUM_TERMS];
  tts_sec_t sec_reg;
  logic [NUM_PAT:0] sto_reg [NUM_TERMS];
  logic [NUM_PAT:0] gsto_reg;

  function automatic tts_branch_t default_branch(input int t);
    tts_branch_t b;
    b.qual = QUAL_ANY;
    b.use_arm = 1'b0;
    b.count = COUNT_DEFAULT;
    if (t == NUM_TERMS - 1) begin
      b.target = TERM_LAST;
    end else begin
      b.target = TERM_W'(t + 1);
    end
    return b;
  endfunction

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg_reg <= '{complex_mode: 1'b0, easy_levels: LEVELS_DEFAULT,
                   trig_term: TERM_LAST, arm_src: TTS_ARM_ALWAYS};
      sec_reg <= '{qual: QUAL_NEVER, target: TERM_FIRST};
      gsto_reg <= QUAL_ANY;
    end else if (CE) begin
      if (REINIT) begin
        cfg_reg <= '{complex_mode: 1'b0, easy_levels: LEVELS_DEFAULT,
                     trig_term: TERM_LAST, arm_src: TTS_ARM_ALWAYS};
        sec_reg <= '{qual: QUAL_NEVER, target: TERM_FIRST};
        gsto_reg <= QUAL_ANY;
      end else begin
        if (CFG_WE) begin
          cfg_reg <= CFG_IN;
          if (CFG_IN.easy_levels == 3'h0 ||
              CFG_IN.easy_levels > 3'(EASY_MAX_LEVELS)) begin
            cfg_reg.easy_levels <= cfg_reg.easy_levels;
          end
        end
        if (SEC_WE) begin
          sec_reg <= SEC_IN;
        end
        if (STO_WE) begin
          gsto_reg <= STO_IN;
        end
      end
    end
  end

  // branch and per-term store tables
  logic br_ok;
  assign br_ok = cfg_reg.complex_mode ||
                 ({1'b0, BR_TERM} < {1'b0, cfg_reg.easy_levels});

  for (genvar g = 0; g < NUM_TERMS; g++) begin : g_term
    always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        br_reg[g] <= default_branch(g);
        sto_reg[g] <= QUAL_ANY;
      end else if (CE) begin
        if (REINIT) begin
          br_reg[g] <= default_branch(g);
          sto_reg[g] <= QUAL_ANY;
        end else if (SIMPLE_TRIGGER_CMD) begin
          br_reg[g] <= default_branch(g);
          if (g == 0) begin
            br_reg[g].qual <= SIMPLE_QUAL;
          end
        end else if (BR_WE && BR_TERM == TERM_W'(g) && br_ok) begin
          br_reg[g] <= BR_IN;
          if (BR_IN.count == '0) begin
            br_reg[g].count <= COUNT_DEFAULT;
          end
        end
        if (!REINIT && STO_WE && BR_TERM == TERM_W'(g)) begin
          sto_reg[g] <= STO_IN;
        end
      end
    end
  end

  // simple trigger also collapses the sequence to one level
  // (handled by the sequencer state below via last-level logic)
  logic simple_mode_reg;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      simple_mode_reg <= 1'b0;
    end else if (CE) begin
      if (REINIT) begin
        simple_mode_reg <= 1'b0;
      end else if (SIMPLE_TRIGGER_CMD) begin
        simple_mode_reg <= 1'b1;
      end else if (CFG_WE || BR_WE) begin
        simple_mode_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CFG_ERR <= 1'b0;
    end else if (CE) begin
      CFG_ERR <= BR_WE && !br_ok;
    end
  end

  // --------------------------------------------------------------
  // qualifier evaluation
  // --------------------------------------------------------------
  logic [TERM_W-1:0] term_reg;
  logic [CNT_W-1:0] occ_reg;
  logic running_reg;
  logic pri_hit;
  logic sec_hit;
  logic sto_hit;
  logic gsto_hit;
  logic arm_ok;
  tts_branch_t cur_br;

  assign cur_br = br_reg[term_reg];

  always_comb begin
    case (cfg_reg.arm_src)
      TTS_ARM_LINE_A: arm_ok = line_a_sync_reg[1];
      TTS_ARM_LINE_B: arm_ok = line_b_sync_reg[1];
      default: arm_ok = 1'b1;
    endcase
  end

  logic pri_raw;
  tts_qual_eval u_pri (
    .qual(cur_br.qual),
    .pat_hit(PAT_HIT),
    .hit(pri_raw)
  );
  assign pri_hit = pri_raw && (!cur_br.use_arm || arm_ok);

  tts_qual_eval u_sec (
    .qual(sec_reg.qual),
    .pat_hit(PAT_HIT),
    .hit(sec_hit)
  );
  tts_qual_eval u_gsto (
    .qual(gsto_reg),
    .pat_hit(PAT_HIT),
    .hit(gsto_hit)
  );
  tts_qual_eval u_tsto (
    .qual(sto_reg[term_reg]),
    .pat_hit(PAT_HIT),
    .hit(sto_hit)
  );

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  logic [TERM_W-1:0] last_term;
  logic count_done;
  logic pri_take;
  logic [TERM_W-1:0] term_next;
  logic trig_next;

  assign last_term = simple_mode_reg ? TERM_FIRST :
                     TERM_W'(cfg_reg.easy_levels - 3'h1);
  assign count_done = (occ_reg + 16'h0001) >= cur_br.count;
  assign pri_take = STATE_VALID && pri_hit && count_done;

  always_comb begin
    term_next = term_reg;
    trig_next = 1'b0;
    if (STATE_VALID && running_reg) begin
      if (pri_take) begin
        if (cfg_reg.complex_mode && !simple_mode_reg) begin
          term_next = cur_br.target;
          trig_next = (term_reg == cfg_reg.trig_term);
        end else if (term_reg == last_term) begin
          trig_next = 1'b1;
        end else begin
          term_next = term_reg + 3'h1;
        end
      end else if (sec_hit) begin
        if (cfg_reg.complex_mode && !simple_mode_reg) begin
          term_next = sec_reg.target;
        end else begin
          term_next = TERM_FIRST;
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      term_reg <= TERM_FIRST;
      running_reg <= 1'b0;
    end else if (CE) begin
      if (REINIT) begin
        term_reg <= TERM_FIRST;
        running_reg <= 1'b0;
      end else if (RUN_START) begin
        term_reg <= TERM_FIRST;
        running_reg <= 1'b1;
      end else begin
        term_reg <= term_next;
        if (trig_next) begin
          running_reg <= 1'b0;
        end
      end
    end
  end

  // occurrence counter
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      occ_reg <= '0;
    end else if (CE) begin
      if (REINIT || RUN_START) begin
        occ_reg <= '0;
      end else if (STATE_VALID && running_reg) begin
        if (pri_take || sec_hit) begin
          occ_reg <= '0;
        end else if (pri_hit) begin
          occ_reg <= occ_reg + 16'h0001;
        end
      end
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      TRIGGER <= 1'b0;
      TRIGGERED <= 1'b0;
      STORE <= 1'b0;
      CUR_TERM <= TERM_FIRST;
    end else if (CE) begin
      TRIGGER <= trig_next && !REINIT && !RUN_START;
      if (REINIT || RUN_START) begin
        TRIGGERED <= 1'b0;
      end else if (trig_next) begin
        TRIGGERED <= 1'b1;
      end
      STORE <= STATE_VALID && running_reg && gsto_hit &&
               (!cfg_reg.complex_mode || sto_hit);
      CUR_TERM <= term_reg;
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  property p_easy_trig;
    @(posedge CLK) disable iff (!ARST_N)
      (CE && running_reg && STATE_VALID && pri_take && !REINIT &&
       !RUN_START && !cfg_reg.complex_mode && !simple_mode_reg &&
       term_reg == last_term) |=> TRIGGER;
  endproperty
  a_easy_trig: assert property (p_easy_trig)
    else $error("easy trigger missed");

  property p_pri_wins;
    @(posedge CLK) disable iff (!ARST_N)
      (CE && running_reg && pri_take && sec_hit && !REINIT &&
       !RUN_START && !cfg_reg.complex_mode && term_reg != last_term)
      |=> term_reg == $past(term_reg) + 3'h1;
  endproperty
  a_pri_wins: assert property (p_pri_wins)
    else $error("primary did not win");

  property p_restart;
    @(posedge CLK) disable iff (!ARST_N)
      (CE && running_reg && STATE_VALID && !pri_hit && sec_hit &&
       !REINIT && !RUN_START && !cfg_reg.complex_mode)
      |=> term_reg == TERM_FIRST && occ_reg == '0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("easy restart failed");

  property p_levels;
    @(posedge CLK) disable iff (!ARST_N)
      cfg_reg.easy_levels >= 3'h1 &&
      cfg_reg.easy_levels <= 3'(EASY_MAX_LEVELS);
  endproperty
  a_levels: assert property (p_levels)
    else $error("level count out of range");

  property p_reinit;
    @(posedge CLK) disable iff (!ARST_N)
      (CE && REINIT) |=> !cfg_reg.complex_mode &&
      sec_reg.qual == QUAL_NEVER && br_reg[0].qual == QUAL_ANY &&
      br_reg[NUM_TERMS-1].target == TERM_LAST && !running_reg;
  endproperty
  a_reinit: assert property (p_reinit)
    else $error("reinit defaults wrong");

  property p_hold_no_state;
    @(posedge CLK) disable iff (!ARST_N)
      (CE && !STATE_VALID && !REINIT && !RUN_START)
      |=> $stable(term_reg) && !TRIGGER;
  endproperty
  a_hold_no_state: assert property (p_hold_no_state)
    else $error("branch without a state");

  property p_simple;
    @(posedge CLK) disable iff (!ARST_N)
      (CE && SIMPLE_TRIGGER_CMD && !REINIT)
      |=> br_reg[0].qual == $past(SIMPLE_QUAL) && simple_mode_reg;
  endproperty
  a_simple: assert property (p_simple)
    else $error("simple trigger not loaded");

  property p_complex_jump;
    @(posedge CLK) disable iff (!ARST_N)
      (CE && running_reg && pri_take && cfg_reg.complex_mode &&
       !simple_mode_reg && !REINIT && !RUN_START)
      |=> term_reg == $past(cur_br.target) ##1
          CUR_TERM == $past(cur_br.target, 2);
  endproperty
  a_complex_jump: assert property (p_complex_jump)
    else $error("complex jump wrong");

  property p_count_default;
    @(posedge CLK) disable iff (!ARST_N)
      (CE && BR_WE && br_ok && !REINIT && !SIMPLE_TRIGGER_CMD &&
       BR_IN.count == '0) |=> br_reg[$past(BR_TERM)].count == COUNT_DEFAULT;
  endproperty
  a_count_default: assert property (p_count_default)
    else $error("default count not one");

  property p_occ_clear;
    @(posedge CLK) disable iff (!ARST_N)
      (CE && running_reg && STATE_VALID && (pri_take || sec_hit) &&
       !REINIT) |=> occ_reg == '0;
  endproperty
  a_occ_clear: assert property (p_occ_clear)
    else $error("occurrence count not cleared");
endmodule // tts_sequencer

// ---- shared/tts_pkg.sv ----
package tts_pkg;
  // sequencer geometry
  localparam int NUM_TERMS = 8;
  localparam int TERM_W = 3;
  localparam int CNT_W = 16;
  localparam int EASY_MAX_LEVELS = 4;
  localparam int NUM_PAT = 8;
  // reset values
  localparam logic [TERM_W-1:0] TERM_FIRST = 3'h0;
  localparam logic [TERM_W-1:0] TERM_LAST = 3'h7;
  localparam logic [CNT_W-1:0] COUNT_DEFAULT = 16'h0001;
  localparam logic [2:0] LEVELS_DEFAULT = 3'h1;
  localparam logic [NUM_PAT:0] QUAL_ANY = 9'h100;
  localparam logic [NUM_PAT:0] QUAL_NEVER = 9'h000;
  // qualifier: bit NUM_PAT = "any", bits below = pattern OR mask
  typedef struct packed {
    logic [NUM_PAT:0] qual;
    logic use_arm;
    logic [TERM_W-1:0] target;
    logic [CNT_W-1:0] count;
  } tts_branch_t;
  typedef struct packed {
    logic [NUM_PAT:0] qual;
    logic [TERM_W-1:0] target;
  } tts_sec_t;
  typedef struct packed {
    logic complex_mode;
    logic [2:0] easy_levels;
    logic [TERM_W-1:0] trig_term;
    logic [1:0] arm_src;
  } tts_cfg_t;
  typedef enum logic [1:0] {
    TTS_ARM_ALWAYS = 2'b00,
    TTS_ARM_LINE_A = 2'b01,
    TTS_ARM_LINE_B = 2'b10
  } tts_arm_t;
endpackage
